// ===== hdl/converter_analog_trim_regs.v
// apb register bank holding converter analog trim and alignment status
//
// The APB interface to the registers was left to the implementer.
`include "trim_regs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module converter_analog_trim_regs #(
  parameter LANES = 16
) (
  // clock and reset
  input  wire                     sys_clk,
  input  wire                     rst,
  // apb slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [11:0]              paddr,
  input  wire [31:0]              pwdata,
  input  wire [3:0]               pstrb,
  output wire                     pready,
  output reg  [31:0]              prdata,
  output wire                     pslverr,
  // edge position measurement from the alignment detector
  input  wire [23:0]              edge_measure,
  input  wire                     edge_measure_done,
  // analog trim outputs
  output wire [15:0]              fullscale_code_a,
  output wire [15:0]              fullscale_code_b,
  output wire                     reference_bypass,
  output wire                     stamp_receiver_on,
  output wire                     stamp_pecl_mode,
  output wire [3*LANES-1:0]       lane_emphasis_level,
  output wire [LANES-1:0]         lane_emphasis_extra
);

  // register storage
  reg  [15:0]                     fs_a_reg;
  reg  [15:0]                     fs_b_reg;
  reg  [7:0]                      ref_ctrl_reg;
  reg  [7:0]                      stamp_ctrl_reg;
  reg  [7:0]                      emph_ctrl_reg;
  reg  [23:0]                     edge_pos_reg;
  reg                             edge_valid_reg;
  reg                             measure_arm_reg;
  reg  [23:0]                     edge_meas_s1_reg;
  reg  [23:0]                     edge_meas_s2_reg;
  reg                             done_s1_reg;
  reg                             done_s2_reg;
  reg                             done_s3_reg;
  reg  [31:0]                     rdata_next;
  reg                             hit_next;

  wire [9:0]                      word_index;
  wire                            aligned;
  wire                            access;
  wire                            wr;
  wire                            done_rise;

  // address decode: index is the byte address over four
  assign word_index = paddr[11:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign access     = psel & penable;
  assign wr         = access & pwrite & aligned & ~pslverr;

  // zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = access & (~aligned | ~hit_next);

  // synchronise the detector outputs (foreign domain)
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      edge_meas_s1_reg <= `RST_EDGE_POSITION;
      edge_meas_s2_reg <= `RST_EDGE_POSITION;
      done_s1_reg      <= 1'b0;
      done_s2_reg      <= 1'b0;
      done_s3_reg      <= 1'b0;
    end
    else
    begin
      edge_meas_s1_reg <= edge_measure;
      edge_meas_s2_reg <= edge_meas_s1_reg;
      done_s1_reg      <= edge_measure_done;
      done_s2_reg      <= done_s1_reg;
      done_s3_reg      <= done_s2_reg;
    end
  end

  assign done_rise = done_s2_reg & ~done_s3_reg;

  // capture of the measured edge position
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      edge_pos_reg    <= `RST_EDGE_POSITION;
      edge_valid_reg  <= 1'b0;
      measure_arm_reg <= 1'b1;
    end
    else
    begin
      if (done_rise & measure_arm_reg)
      begin
        edge_pos_reg    <= edge_meas_s2_reg;
        edge_valid_reg  <= 1'b1;
        measure_arm_reg <= 1'b0; // one capture per arm
      end
      // rearm clears valid, new capture wins
      else if (wr && word_index == {2'b00, `IDX_EDGE_CTRL} && pstrb[0]
               && pwdata[`BIT_EDGE_MEASURE])
        edge_valid_reg <= 1'b0;
      if (wr && word_index == {2'b00, `IDX_EDGE_CTRL} && pstrb[0])
        measure_arm_reg <= pwdata[`BIT_EDGE_MEASURE] | ~edge_valid_reg;
    end
  end

  // writable configuration registers
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      fs_a_reg       <= `RST_FULLSCALE;
      fs_b_reg       <= `RST_FULLSCALE;
      ref_ctrl_reg   <= `RST_BYTE;
      stamp_ctrl_reg <= `RST_BYTE;
      emph_ctrl_reg  <= `RST_BYTE;
    end
    else if (wr)
    begin
      case (word_index)
        {2'b00, `IDX_FULLSCALE_A}:
        begin
          if (pstrb[0])
            fs_a_reg[7:0] <= pwdata[7:0];
          if (pstrb[1])
            fs_a_reg[15:8] <= pwdata[15:8];
        end
        {2'b00, `IDX_FULLSCALE_B}:
        begin
          if (pstrb[0])
            fs_b_reg[7:0] <= pwdata[7:0];
          if (pstrb[1])
            fs_b_reg[15:8] <= pwdata[15:8];
        end
        {2'b00, `IDX_REFERENCE_CTRL}:
        begin
          if (pstrb[0])
            ref_ctrl_reg <= {7'h00, pwdata[0]};
        end
        {2'b00, `IDX_STAMP_CTRL}:
        begin
          if (pstrb[0])
            stamp_ctrl_reg <= {6'h00, pwdata[1:0]};
        end
        {2'b00, `IDX_EMPHASIS_CTRL}:
        begin
          if (pstrb[0])
            emph_ctrl_reg <= {4'h0, pwdata[3:0]};
        end
        default:
        begin
          fs_a_reg <= fs_a_reg;
        end
      endcase
    end
  end

  // read mux and hit decode
  always @*
  begin
    rdata_next = 32'h00000000;
    hit_next   = 1'b1;
    case (word_index)
      {2'b00, `IDX_EDGE_POSITION}:  rdata_next = {8'h00, edge_pos_reg};
      {2'b00, `IDX_EDGE_CTRL}:      rdata_next = {31'h00000000, edge_valid_reg};
      {2'b00, `IDX_FULLSCALE_A}:    rdata_next = {16'h0000, fs_a_reg};
      {2'b00, `IDX_FULLSCALE_B}:    rdata_next = {16'h0000, fs_b_reg};
      {2'b00, `IDX_REFERENCE_CTRL}: rdata_next = {24'h000000, ref_ctrl_reg};
      {2'b00, `IDX_STAMP_CTRL}:     rdata_next = {24'h000000, stamp_ctrl_reg};
      {2'b00, `IDX_EMPHASIS_CTRL}:  rdata_next = {24'h000000, emph_ctrl_reg};
      default:                      hit_next   = 1'b0;
    endcase
  end

  // registered read data, updated at each read access
  always @(posedge sys_clk)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
      prdata <= aligned ? rdata_next : 32'h00000000;
  end

  // full-scale codes to the input stages
  assign fullscale_code_a = fs_a_reg;
  assign fullscale_code_b = fs_b_reg;

  assign reference_bypass = ref_ctrl_reg[`BIT_REFERENCE_BYPASS];

  assign stamp_receiver_on = stamp_ctrl_reg[`BIT_STAMP_RECEIVER_ON];
  assign stamp_pecl_mode   = stamp_ctrl_reg[`BIT_STAMP_PECL_MODE];

  // one global emphasis setting fanned to every lane
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane_fan
      assign lane_emphasis_level[3*g +: 3] = emph_ctrl_reg[2:0];
      assign lane_emphasis_extra[g] = emph_ctrl_reg[`BIT_EMPHASIS_EXTRA];
    end
  endgenerate

endmodule
`default_nettype wire

// ===== common/trim_regs_map.vh
// register offsets, field positions and reset values of the converter trim registers
`ifndef TRIM_REGS_MAP_VH
`define TRIM_REGS_MAP_VH

// printed offsets are register indices; byte address is four times the index
`define IDX_EDGE_POSITION      8'h2C
`define IDX_FULLSCALE_A        8'h30
`define IDX_FULLSCALE_B        8'h32
`define IDX_REFERENCE_CTRL     8'h38
`define IDX_STAMP_CTRL         8'h3B
`define IDX_EMPHASIS_CTRL      8'h48
`define IDX_EDGE_CTRL          8'h2D

// reset values
`define RST_FULLSCALE          16'hA000
`define RST_BYTE               8'h00
`define RST_EDGE_POSITION      24'h000000

// field positions
`define BIT_REFERENCE_BYPASS   0
`define BIT_STAMP_RECEIVER_ON  0
`define BIT_STAMP_PECL_MODE    1
`define BIT_EMPHASIS_EXTRA     3
`define BIT_EDGE_VALID         0
`define BIT_EDGE_MEASURE       0

// field widths
`define W_EDGE_POSITION        24
`define W_FULLSCALE            16
`define W_EMPHASIS_LEVEL       3

`endif

// ===== verification/trim_regs_properties.sv
// port assertions for the converter trim register bank
`timescale 1ns/1ps
`default_nettype none
module trim_regs_properties #(parameter LANES = 16) (
  // clock, reset and apb
  input wire logic sys_clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  // trim outputs
  input wire logic [15:0] fullscale_code_a, fullscale_code_b,
  input wire logic reference_bypass, stamp_receiver_on, stamp_pecl_mode,
  input wire logic [3*LANES-1:0] lane_emphasis_level,
  input wire logic [LANES-1:0] lane_emphasis_extra
);
  default clocking @(posedge sys_clk); endclocking
  // completed write with the two low byte strobes set
  wire logic wr = psel && penable && pwrite && pready && pstrb[1:0] == 2'b11;
  chk_code_a_wr: assert property (disable iff (rst)
    wr && paddr == 12'h0C0 |=> fullscale_code_a == $past(pwdata[15:0])) else $error("code a");
  chk_code_b_wr: assert property (disable iff (rst)
    wr && paddr == 12'h0C8 |=> fullscale_code_b == $past(pwdata[15:0])) else $error("code b");
  chk_reset_codes: assert property (disable iff (1'b0) rst |=>
    fullscale_code_a == 16'hA000 && fullscale_code_b == 16'hA000 && !stamp_receiver_on)
    else $error("reset codes");
  chk_bypass_wr: assert property (disable iff (rst)
    wr && paddr == 12'h0E0 |=> reference_bypass == $past(pwdata[0])) else $error("bypass");
  chk_stamp_wr: assert property (disable iff (rst) wr && paddr == 12'h0EC |=>
    {stamp_pecl_mode, stamp_receiver_on} == $past(pwdata[1:0])) else $error("stamp");
  chk_level_wr: assert property (disable iff (rst) wr && paddr == 12'h120 |=>
    lane_emphasis_level == {LANES{$past(pwdata[2:0])}}) else $error("level");
  chk_extra_wr: assert property (disable iff (rst) wr && paddr == 12'h120 |=>
    lane_emphasis_extra == {LANES{$past(pwdata[3])}}) else $error("extra");
  chk_hold_cfg: assert property (disable iff (rst) !(psel && pwrite) |=>
    $stable(fullscale_code_a) && $stable(lane_emphasis_level)) else $error("hold");
  chk_bad_err: assert property (disable iff (rst)
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr) else $error("misaligned");
  chk_bad_data: assert property (disable iff (rst)
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0) else $error("refused data");
  cov_code_wr: cover property (wr && paddr == 12'h0C0);
  cov_refused: cover property (psel && penable && pslverr);
  cov_emph_wr: cover property (wr && paddr == 12'h120);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the converter trim register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, edge_measure_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, d, seed = 32'h611C;
  logic [3:0] pstrb = 4'hF;
  logic [23:0] edge_measure = 0, e;
  logic [15:0] fullscale_code_a, fullscale_code_b, lane_emphasis_extra;
  logic reference_bypass, stamp_receiver_on, stamp_pecl_mode, pready, pslverr, err;
  logic [31:0] prdata;
  logic [47:0] lane_emphasis_level;
  logic [31:0] sh [5];
  logic [11:0] adr [5] = '{12'h0C0, 12'h0C8, 12'h0E0, 12'h0EC, 12'h120};
  logic [31:0] msk [5] = '{32'hFFFF, 32'hFFFF, 32'h1, 32'h3, 32'hF};
  integer miscompares = 0, checked = 0, i, n;
  wire logic [98:0] outs = {fullscale_code_a, fullscale_code_b, reference_bypass,
    stamp_pecl_mode, stamp_receiver_on, lane_emphasis_level, lane_emphasis_extra};
  converter_analog_trim_regs #(.LANES(16)) i_dut (.*);
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // expected trim outputs from the shadow registers
  function automatic logic [98:0] outs_exp();
    return {sh[0][15:0], sh[1][15:0], sh[2][0], sh[3][1:0], {16{sh[4][2:0]}}, {16{sh[4][3]}}};
  endfunction
  task automatic check(input logic [98:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk) penable <= 1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (n == 20) miscompares++;
    if (n == 20) finish_test();
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  initial forever #12.5 sys_clk = ~sys_clk;
  // main sequence
  initial
  begin
    sh = '{32'hA000, 32'hA000, 32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    for (i = 0; i < 30; i++)
    begin
      apb(0, adr[i%5], 0);
      check(rd, sh[i%5]);
      seed = xs(seed);
      d = (i == 0) ? 32'hFFFF : (i == 1) ? 32'h1FFF : seed;
      apb(1, adr[i%5], d);
      sh[i%5] = d & msk[i%5];
      check(outs, outs_exp());
    end
    pstrb <= 4'hE;
    apb(1, 12'h0C0, 32'h1234);
    pstrb <= 4'hF;
    sh[0][15:8] = 8'h12;
    check(outs, outs_exp());
    apb(1, 12'h004, 32'hFFFF);
    check(outs, outs_exp());
    apb(0, 12'h004, 0);
    check({err, rd}, {1'b1, 32'h0});
    apb(0, 12'h0C1, 0);
    check(err, 1'b1);
    e = seed[23:0];
    edge_measure <= e;
    edge_measure_done <= 1;
    repeat (6) @(posedge sys_clk);
    edge_measure <= ~e;
    apb(0, 12'h0B0, 0);
    check(rd, {8'h00, e});
    apb(1, 12'h0B0, 32'h00ABCDEF);
    apb(0, 12'h0B0, 0);
    check(rd, {8'h00, e});
    apb(0, 12'h0B4, 0);
    check(rd, 32'h1);
    apb(1, 12'h0B4, 32'h1);
    apb(0, 12'h0B4, 0);
    check(rd, 32'h0);
    edge_measure_done <= 0;
    repeat (4) @(posedge sys_clk);
    edge_measure_done <= 1;
    repeat (6) @(posedge sys_clk);
    apb(0, 12'h0B0, 0);
    check(rd, {8'h00, ~e});
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    sh = '{32'hA000, 32'hA000, 32'h0, 32'h0, 32'h0};
    check(outs, outs_exp());
    finish_test();
  end
endmodule
bind converter_analog_trim_regs trim_regs_properties #(.LANES(LANES)) i_chk (.*);
`default_nettype wire
